// ==== hdl/mjs_jam_stage.v ====
// Load jam overcurrent stage with APB registers, events, counters and fault records
//
// Design decisions made here: the APB register port and the placing of the registers.
`include "mjs_defines.vh"

// Contract
// - Locked rotor uses hot curve above theta limit, else capacity-adjusted cold curve.
// - Same theta limit picks curve for starts when hot/cold start selection enabled.
// - Cold stall time defaults 20.0 s, 0.1 s steps; zero means use hot.
// - Hot stall time defaults 15.0 s and is used on the hot curve.
// - Highest phase current compared to pick-up, default 6.00 xIn, 0.10 steps.
// - Only definite delay timing towards trip.
// - Active setting group switchable while running.
// - Blocking input sampled once at each program cycle start.
// - Pick-up while unblocked asserts start and runs delay timing.
// - Pick-up while blocked asserts blocked, no timing or trip.
// - Blocking after start clears start and releases timing.
// - Rising and falling events for start, trip and blocked, six kinds.
// - Per-event enable selects which messages reach the event buffer.
// - Every stored event carries a time stamp.
// - Cumulative counters for start, trip and blocked activations.
// - Each activation writes a twelve-entry circular fault record.
// - Record holds stamp, event, phases, currents, remaining time, setting group.
// - Remaining and expected time to trip exposed in 5 ms units.
// - Reports behaviour mode and condition normal, start, trip or blocked.
module mjs_jam_stage #(
  parameter PROG_CYC_CLKS = `MJS_PROG_CYC_CLKS,
  parameter CW = 16
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  input wire [CW-1:0] i_cur_l1,
  input wire [CW-1:0] i_cur_l2,
  input wire [CW-1:0] i_cur_l3,
  input wire i_block,
  input wire [9:0] i_theta_used,
  input wire i_locked_rotor,
  input wire i_motor_starting,
  input wire [31:0] i_time_ms,
  output reg o_start,
  output reg o_trip,
  output reg o_blocked,
  output reg o_hot_curve,
  output reg [12:0] o_stall_time,
  output reg o_evt_valid,
  output reg [2:0] o_evt_code,
  output reg [31:0] o_evt_stamp
);
  localparam HW = 6;
  // Registers and state
  reg [7:0] ctrl_q;
  reg [12:0] cold_q, hot_q;
  reg [9:0] hotlim_q;
  reg [5:0] evtcfg_q;
  reg [8:0] pickup_q [0:`MJS_GROUPS-1];
  reg [15:0] delay_q [0:`MJS_GROUPS-1];
  reg [3:0] rec_sel_q, rec_wp_q;
  reg [31:0] cnt_start_q, cnt_trip_q, cnt_block_q, div_q, stamp_q;
  reg blk_s1_q, blk_s2_q, blk_q;
  reg st_q, tr_q, bk_q;
  reg [15:0] timer_q, remain_q;
  reg [5:0] pend_q;
  reg [CW-1:0] hist_q [0:`MJS_PRE_FAULT_CYC-1];
  reg [HW-1:0] hptr_q;
  reg [CW-1:0] pre_trig_q, fault_cur_q, pre_fault_q;
  reg [2:0] phases_q, grp_q;
  reg [31:0] rec_stamp_q [0:`MJS_REC_DEPTH-1], rec_w1_q [0:`MJS_REC_DEPTH-1];
  reg [31:0] rec_w2_q [0:`MJS_REC_DEPTH-1], rec_w3_q [0:`MJS_REC_DEPTH-1];
  integer k, j;

  wire tick = (div_q == PROG_CYC_CLKS - 1);
  wire [2:0] mode = ctrl_q[2:0];
  wire hc_start_en = ctrl_q[3];
  wire [2:0] grp = ctrl_q[6:4];
  wire stage_off = (mode > `MJS_MODE_TEST_BLK);
  wire test_mode = (mode == `MJS_MODE_TEST) || (mode == `MJS_MODE_TEST_BLK);
  wire mode_blk = (mode == `MJS_MODE_BLOCKED) || (mode == `MJS_MODE_TEST_BLK);

  wire [CW-1:0] max12 = (i_cur_l1 > i_cur_l2) ? i_cur_l1 : i_cur_l2;
  wire [CW-1:0] imax = (max12 > i_cur_l3) ? max12 : i_cur_l3;
  wire [CW+3:0] thr = pickup_q[grp] * `MJS_PICKUP_SCALE;
  wire [2:0] over = {({4'h0, i_cur_l3} >= thr), ({4'h0, i_cur_l2} >= thr),
                     ({4'h0, i_cur_l1} >= thr)};
  wire pick = ({4'h0, imax} >= thr);
  wire [15:0] dly = (delay_q[grp] == 16'h0000) ? 16'h0001 : delay_q[grp];
  wire [15:0] timer_nx = timer_q + 16'h0001;

  wire [12:0] cold_eff = (cold_q == 13'h0000) ? hot_q : cold_q;
  wire [9:0] theta = (i_theta_used > `MJS_THETA_FULL) ? `MJS_THETA_FULL : i_theta_used;
  wire [22:0] cold_prod = cold_eff * (`MJS_THETA_FULL - theta);
  wire [22:0] cold_div = cold_prod / `MJS_THETA_FULL;
  wire [12:0] cold_adj = cold_div[12:0];
  wire is_hot = (theta > hotlim_q);
  // starts use curve choice when enabled
  wire curve_act = i_locked_rotor || (i_motor_starting && hc_start_en);

  // Next stage state at each program cycle
  reg st_d, tr_d, bk_d;
  reg [15:0] timer_d;
  always @* begin
    st_d = 1'b0;
    tr_d = 1'b0;
    bk_d = 1'b0;
    timer_d = 16'h0000;
    if (!stage_off && pick) begin
      if (blk_q) begin
        bk_d = 1'b1;
      end else begin
        st_d = 1'b1;
        timer_d = (timer_q >= dly) ? dly : timer_nx;
        tr_d = (timer_nx >= dly) || tr_q;
      end
    end
  end

  // Event edges found at this program cycle
  wire [5:0] edges = {bk_q & ~bk_d, ~bk_q & bk_d, tr_q & ~tr_d, ~tr_q & tr_d,
                      st_q & ~st_d, ~st_q & st_d};
  reg [2:0] ev_sel;
  always @* begin
    ev_sel = 3'h0;
    for (j = 5; j >= 0; j = j - 1) begin
      if (pend_q[j]) begin
        ev_sel = j[2:0];
      end
    end
  end
  wire ev_go = |pend_q;
  wire ev_on = ev_go && !ev_sel[0];
  // Program cycle divider
  always @(posedge i_sys_clk) begin
    if (i_rst || tick) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // block synchronised, sampled once per cycle
  // late block still acts next cycle
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      blk_s1_q <= i_block;
      blk_s2_q <= blk_s1_q;
      if (tick) begin
        blk_q <= blk_s2_q || mode_blk;
      end
    end
  end

  // Stage state, current history and record snapshot
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= 1'b0;
      tr_q <= 1'b0;
      bk_q <= 1'b0;
      timer_q <= 16'h0000;
      hptr_q <= {HW{1'b0}};
      stamp_q <= 32'h0;
      pre_trig_q <= {CW{1'b0}};
      fault_cur_q <= {CW{1'b0}};
      pre_fault_q <= {CW{1'b0}};
      phases_q <= 3'h0;
      remain_q <= 16'h0000;
      grp_q <= 3'h0;
    end else if (tick) begin
      st_q <= st_d;
      tr_q <= tr_d;
      bk_q <= bk_d;
      timer_q <= timer_d;
      hist_q[hptr_q] <= imax;
      hptr_q <= (hptr_q == `MJS_PRE_FAULT_CYC - 1) ? {HW{1'b0}} : hptr_q + 1'b1;
      if (|edges) begin
        stamp_q <= i_time_ms;
        pre_trig_q <= hist_q[(hptr_q + `MJS_PRE_FAULT_CYC - `MJS_PRE_TRIG_CYC)
                             % `MJS_PRE_FAULT_CYC];
        fault_cur_q <= imax;
        phases_q <= over;
        remain_q <= tr_d ? 16'h0000 : dly - timer_d;
        grp_q <= grp;
        if (edges[0]) begin
          pre_fault_q <= hist_q[hptr_q];
        end
      end
    end
  end

  // six event kinds drained one per clock
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      pend_q <= 6'h00;
      o_evt_valid <= 1'b0;
      o_evt_code <= 3'h0;
      o_evt_stamp <= 32'h0;
    end else begin
      pend_q <= (pend_q & ~(ev_go ? (6'h01 << ev_sel) : 6'h00)) | (tick ? edges : 6'h00);
      o_evt_valid <= ev_go && evtcfg_q[ev_sel];
      if (ev_go) begin
        o_evt_code <= ev_sel;
        o_evt_stamp <= stamp_q;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_start_q <= 32'h0;
      cnt_trip_q <= 32'h0;
      cnt_block_q <= 32'h0;
    end else if (tick) begin
      cnt_start_q <= cnt_start_q + {31'h0, edges[0]};
      cnt_trip_q <= cnt_trip_q + {31'h0, edges[2]};
      cnt_block_q <= cnt_block_q + {31'h0, edges[4]};
    end
  end

  // circular store of last twelve activations
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      rec_wp_q <= 4'h0;
    end else if (ev_on) begin
      rec_stamp_q[rec_wp_q] <= stamp_q;
      rec_w1_q[rec_wp_q] <= {5'h0, grp_q, 1'b0, phases_q, 1'b0, ev_sel, remain_q};
      rec_w2_q[rec_wp_q] <= {pre_trig_q, fault_cur_q};
      rec_w3_q[rec_wp_q] <= {16'h0000, pre_fault_q};
      rec_wp_q <= (rec_wp_q == `MJS_REC_DEPTH - 1) ? 4'h0 : rec_wp_q + 4'h1;
    end
  end

  // hot or adjusted cold stall curve when a curve is active, else unadjusted cold time
  // hot curve selects hot time
  // Test modes keep start, trip and blocked outputs quiet
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_hot_curve <= 1'b0;
      o_stall_time <= 13'h0000;
      o_start <= 1'b0;
      o_trip <= 1'b0;
      o_blocked <= 1'b0;
    end else begin
      o_hot_curve <= curve_act && is_hot;
      o_stall_time <= !curve_act ? cold_eff : (is_hot ? hot_q : cold_adj);
      o_start <= st_q && !test_mode;
      o_trip <= tr_q && !test_mode;
      o_blocked <= bk_q && !test_mode;
    end
  end

  // APB write decode, groups at their own words
  wire apb_wr = i_psel && i_penable && i_pwrite;
  wire apb_setup = i_psel && !i_penable;
  wire in_pk = (i_paddr[7:5] == 3'h2);
  wire in_dl = (i_paddr[7:5] == 3'h3);
  wire [2:0] gidx = i_paddr[4:2];
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_q <= `MJS_RST_CTRL;
      cold_q <= `MJS_RST_COLD;
      hot_q <= `MJS_RST_HOT;
      hotlim_q <= `MJS_RST_HOTLIM;
      evtcfg_q <= `MJS_RST_EVTCFG;
      rec_sel_q <= 4'h0;
      for (k = 0; k < `MJS_GROUPS; k = k + 1) begin
        pickup_q[k] <= `MJS_RST_PICKUP;
        delay_q[k] <= `MJS_RST_DELAY;
      end
    end else if (apb_wr) begin
      case (i_paddr)
        `MJS_A_CTRL: ctrl_q <= i_pwdata[7:0];
        `MJS_A_STALL: begin
          cold_q <= i_pwdata[12:0];
          hot_q <= i_pwdata[28:16];
        end
        `MJS_A_HOTLIM: hotlim_q <= i_pwdata[9:0];
        `MJS_A_EVTCFG: evtcfg_q <= i_pwdata[5:0];
        `MJS_A_REC_SEL: rec_sel_q <= (i_pwdata[3:0] < `MJS_REC_DEPTH) ? i_pwdata[3:0] : 4'h0;
        default: begin
          if (in_pk) begin
            pickup_q[gidx] <= i_pwdata[8:0];
          end
          if (in_dl) begin
            delay_q[gidx] <= i_pwdata[15:0];
          end
        end
      endcase
    end
  end

  wire [1:0] cond = tr_q ? `MJS_COND_TRIP : st_q ? `MJS_COND_START :
                    bk_q ? `MJS_COND_BLOCKED : `MJS_COND_NORMAL;
  wire [15:0] remain_now = st_q ? (dly - timer_q) : 16'h0000;
  // Record slot shown for reading
  wire [31:0] rs_full = (rec_wp_q + `MJS_REC_DEPTH - 1 - rec_sel_q) % `MJS_REC_DEPTH;
  wire [3:0] rs = rs_full[3:0];
  // Read data captured in setup, shown in access
  reg [31:0] rd_d;
  reg err_d;
  always @* begin
    rd_d = 32'h0;
    err_d = 1'b0;
    case (i_paddr)
      `MJS_A_CTRL: rd_d = {24'h0, ctrl_q};
      `MJS_A_STALL: rd_d = {3'h0, hot_q, 3'h0, cold_q};
      `MJS_A_HOTLIM: rd_d = {22'h0, hotlim_q};
      `MJS_A_EVTCFG: rd_d = {26'h0, evtcfg_q};
      `MJS_A_STATUS: rd_d = {24'h0, bk_q, tr_q, st_q, cond, mode};
      `MJS_A_TIMES: rd_d = {dly, remain_now};
      `MJS_A_CNT_START: rd_d = cnt_start_q;
      `MJS_A_CNT_TRIP: rd_d = cnt_trip_q;
      `MJS_A_CNT_BLOCK: rd_d = cnt_block_q;
      `MJS_A_REC_SEL: rd_d = {24'h0, rec_wp_q, rec_sel_q};
      `MJS_A_REC_W0: rd_d = rec_stamp_q[rs];
      `MJS_A_REC_W1: rd_d = rec_w1_q[rs];
      `MJS_A_REC_W2: rd_d = rec_w2_q[rs];
      `MJS_A_REC_W3: rd_d = rec_w3_q[rs];
      default: begin
        if (in_pk) begin
          rd_d = {23'h0, pickup_q[gidx]};
        end else if (in_dl) begin
          rd_d = {16'h0, delay_q[gidx]};
        end else begin
          err_d = 1'b1;
        end
      end
    endcase
  end
  // APB answer registers
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (apb_setup) begin
      o_prdata <= i_pwrite ? 32'h0 : rd_d;
      o_pslverr <= err_d;
    end
  end

  // Zero-wait access phase
  assign o_pready = 1'b1;
endmodule // mjs_jam_stage

// ==== hdl/mjs_defines.vh ====
// Constants for the motor load jam overcurrent stage
`ifndef MJS_DEFINES_VH
`define MJS_DEFINES_VH
`define MJS_CLK_HZ 250000000
`define MJS_PROG_CYC_MS 5
`define MJS_PROG_CYC_CLKS (`MJS_CLK_HZ / 1000 * `MJS_PROG_CYC_MS)
`define MJS_PRE_TRIG_MS 20
`define MJS_PRE_TRIG_CYC (`MJS_PRE_TRIG_MS / `MJS_PROG_CYC_MS)
`define MJS_PRE_FAULT_MS 200
`define MJS_PRE_FAULT_CYC (`MJS_PRE_FAULT_MS / `MJS_PROG_CYC_MS)
`define MJS_REC_DEPTH 12
`define MJS_GROUPS 8
`define MJS_A_CTRL 8'h00
`define MJS_A_STALL 8'h04
`define MJS_A_HOTLIM 8'h08
`define MJS_A_EVTCFG 8'h0c
`define MJS_A_STATUS 8'h10
`define MJS_A_TIMES 8'h14
`define MJS_A_CNT_START 8'h18
`define MJS_A_CNT_TRIP 8'h1c
`define MJS_A_CNT_BLOCK 8'h20
`define MJS_A_REC_SEL 8'h24
`define MJS_A_REC_W0 8'h28
`define MJS_A_REC_W1 8'h2c
`define MJS_A_REC_W2 8'h30
`define MJS_A_REC_W3 8'h34
`define MJS_A_PICKUP0 8'h40
`define MJS_A_DELAY0 8'h60
`define MJS_RST_CTRL 8'h00
`define MJS_RST_COLD 13'h00c8
`define MJS_RST_HOT 13'h0096
`define MJS_RST_HOTLIM 10'h2bc
`define MJS_RST_EVTCFG 6'h3f
`define MJS_RST_PICKUP 9'h03c
`define MJS_RST_DELAY 16'h00c8
`define MJS_THETA_FULL 10'h3e8
`define MJS_PICKUP_SCALE 4'ha
`define MJS_MODE_ON 3'h0
`define MJS_MODE_BLOCKED 3'h1
`define MJS_MODE_TEST 3'h2
`define MJS_MODE_TEST_BLK 3'h3
`define MJS_MODE_OFF 3'h4
`define MJS_COND_NORMAL 2'h0
`define MJS_COND_START 2'h1
`define MJS_COND_TRIP 2'h2
`define MJS_COND_BLOCKED 2'h3
`define MJS_EV_START_ON 3'h0
`define MJS_EV_START_OFF 3'h1
`define MJS_EV_TRIP_ON 3'h2
`define MJS_EV_TRIP_OFF 3'h3
`define MJS_EV_BLOCK_ON 3'h4
`define MJS_EV_BLOCK_OFF 3'h5
`endif

// ==== sim/mjs_jam_stage_properties.sv ====
// Port-level assertions for the jam stage
`include "mjs_defines.vh"
module mjs_jam_stage_properties #(
  parameter PROG_CYC_CLKS = 10
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire o_start,
  input wire o_trip,
  input wire o_blocked,
  input wire o_hot_curve,
  input wire o_evt_valid,
  input wire [2:0] o_evt_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Bus answers at once and flags holes in the map
  property p_rdy; i_psel && i_penable |-> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_wr_zero; i_psel && i_penable && i_pwrite |-> o_prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data not zero on write");
  property p_unmap; i_psel && !i_penable && i_paddr == 8'hfc |=> o_pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("no error on unmapped address");
  // Stage output relations
  property p_blk_excl; o_blocked |-> !o_start && !o_trip; endproperty
  a_blk_excl: assert property (p_blk_excl) else $error("blocked with start or trip");
  property p_trip_start; $rose(o_trip) |-> o_start; endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  // Event codes agree with the levels they report
  property p_ev_start; o_evt_valid && o_evt_code == `MJS_EV_START_ON |-> o_start; endproperty
  a_ev_start: assert property (p_ev_start) else $error("start event without start");
  property p_ev_trip; o_evt_valid && o_evt_code == `MJS_EV_TRIP_ON |-> o_trip; endproperty
  a_ev_trip: assert property (p_ev_trip) else $error("trip event without trip");
  property p_ev_blk; o_evt_valid && o_evt_code == `MJS_EV_BLOCK_ON |-> o_blocked; endproperty
  a_ev_blk: assert property (p_ev_blk) else $error("block event without blocked");
  property p_ev_off; o_evt_valid && o_evt_code == `MJS_EV_START_OFF |-> !o_start; endproperty
  a_ev_off: assert property (p_ev_off) else $error("start off event with start");
  property p_code; o_evt_valid |-> o_evt_code <= 3'h5; endproperty
  a_code: assert property (p_code) else $error("event code out of range");
  property p_pulse; o_evt_valid |=> !(o_evt_valid && $stable(o_evt_code)); endproperty
  a_pulse: assert property (p_pulse) else $error("event repeated");
  c_trip: cover property ($rose(o_trip));
  c_blk: cover property ($rose(o_blocked));
  c_off: cover property (o_evt_valid && o_evt_code == `MJS_EV_BLOCK_OFF);
  c_hot: cover property ($rose(o_hot_curve));
endmodule // mjs_jam_stage_properties

bind mjs_jam_stage mjs_jam_stage_properties #(.PROG_CYC_CLKS(PROG_CYC_CLKS)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked),
  .o_hot_curve(o_hot_curve), .o_evt_valid(o_evt_valid), .o_evt_code(o_evt_code));

// ==== sim/mjs_far_side.sv ====
// Far side model: phase currents, blocking matrix and time base
module mjs_far_side (
  input wire i_clk,
  input wire i_rst,
  input wire [15:0] i_peak,
  input wire [1:0] i_ph,
  input wire i_blk_cmd,
  output logic [15:0] o_l1,
  output logic [15:0] o_l2,
  output logic [15:0] o_l3,
  output logic o_block,
  output logic [31:0] o_ms
);
  timeunit 1ns;
  timeprecision 1ps;
  // Peak on the chosen phase, fresh noise under pick-up on the others
  always @(posedge i_clk) begin
    o_l1 <= (i_ph == 2'h0) ? i_peak : 16'($urandom % 500);
    o_l2 <= (i_ph == 2'h1) ? i_peak : 16'($urandom % 500);
    o_l3 <= (i_ph == 2'h2) ? i_peak : 16'($urandom % 500);
  end
  // block raised well ahead of delay expiry
  always @(posedge i_clk) o_block <= i_blk_cmd;
  always @(posedge i_clk) o_ms <= i_rst ? 32'h0 : o_ms + 32'h1;
endmodule // mjs_far_side

// ==== sim/mjs_jam_stage_tb_top.sv ====
// Self-checking bench for the jam stage
module mjs_jam_stage_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 10;
  logic i_sys_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, bcmd = 0, lock = 0, mst = 0;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, rdat;
  logic [15:0] peak = 0;
  logic [1:0] ph = 0;
  logic [9:0] theta = 0;
  logic rerr;
  wire rdy, perr, blk, ost, otr, obl, hot, ev;
  wire [31:0] prd, ms, stamp;
  wire [15:0] l1, l2, l3;
  wire [12:0] stall;
  wire [2:0] code;
  logic [2:0] exp_q[$];
  int err_total = 0, num_checks = 0, n;
  logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40, 8'h5c, 8'h60, 8'h7c};
  logic [31:0] rv[8] = '{32'h0, 32'h0096_00c8, 32'h2bc, 32'h3f, 32'h3c, 32'h3c, 32'hc8, 32'hc8};

  mjs_jam_stage #(.PROG_CYC_CLKS(P)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy),
    .o_prdata(prd), .o_pslverr(perr), .i_cur_l1(l1), .i_cur_l2(l2), .i_cur_l3(l3),
    .i_block(blk), .i_theta_used(theta), .i_locked_rotor(lock), .i_motor_starting(mst),
    .i_time_ms(ms), .o_start(ost), .o_trip(otr), .o_blocked(obl), .o_hot_curve(hot),
    .o_stall_time(stall), .o_evt_valid(ev), .o_evt_code(code), .o_evt_stamp(stamp));
  mjs_far_side u_far (.i_clk(i_sys_clk), .i_rst(i_rst), .i_peak(peak), .i_ph(ph),
    .i_blk_cmd(bcmd), .o_l1(l1), .o_l2(l2), .o_l3(l3), .o_block(blk), .o_ms(ms));

  // Clock at 250 MHz
  always #2 i_sys_clk = ~i_sys_clk;

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t %s", $time, m);
      err_total++;
    end
  endtask
  // One APB transfer, then one idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge i_sys_clk);
    pen <= 1;
    k = 0;
    do begin @(posedge i_sys_clk); k++; end while (rdy !== 1'b1 && k < 20);
    if (k >= 20) begin chk(0, 1, "bus timeout"); close_out; end
    rdat = prd; rerr = perr;
    psel <= 0; pen <= 0;
    @(posedge i_sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task tk(input int t); repeat (t * P) @(posedge i_sys_clk); endtask
  task ex(input logic [2:0] c); exp_q.push_back(c); endtask
  task cur(input logic [15:0] v); ph <= 2'($urandom % 3); peak <= v; endtask
  task flush(input string s);
    tk(4);
    chk(exp_q.size(), 0, "events missing");
    $display("test %s done", s);
  endtask
  task lim; if (n >= 400) begin chk(0, 1, "wait timeout"); close_out; end endtask

  // Event buffer side: each stored event against the oldest expectation
  always @(posedge i_sys_clk) if (ev === 1'b1) begin
    if (exp_q.size() == 0) chk(1, 0, "unexpected event");
    else chk(code, exp_q.pop_front(), "event code");
    chk(stamp <= ms && stamp + 3 * P >= ms, 1, "event stamp");
  end

  initial begin
    void'($urandom(67355));
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 0;
    @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin apb(0, ra[i], 0); chk(rdat, rv[i], "reset value"); end
    apb(0, 8'hfc, 0); chk(rerr, 1, "unmapped error");
    $display("test registers done");
    wr(8'h60, 3);
    cur(599); tk(3); chk(ost, 0, "start below pick-up");
    ex(0); ex(2); cur(600);
    n = 0; while (ost !== 1'b1 && n < 400) begin @(posedge i_sys_clk); n++; end lim;
    n = 0; while (otr !== 1'b1 && n < 400) begin @(posedge i_sys_clk); n++; end lim;
    chk(n, 2 * P, "trip delay");
    ex(1); ex(3); cur(0); flush("trip");
    bcmd <= 1; tk(2); ex(4); cur(700); tk(3); chk(ost, 0, "start while blocked");
    chk(obl, 1, "blocked output");
    ex(5); cur(0); flush("blocked"); bcmd <= 0; tk(2);
    wr(8'h60, 20); ex(0); cur(700); tk(3);
    apb(0, 8'h14, 0); chk(rdat[31:16], 20, "expected time");
    chk(rdat[15:0] > 0 && rdat[15:0] < 20, 1, "remaining time");
    ex(1); ex(4); bcmd <= 1; tk(3); chk(otr, 0, "no trip after block");
    ex(5); cur(0); flush("late block"); bcmd <= 0; tk(2);
    wr(8'h0c, 32'h3e); cur(700); tk(3); ex(1); cur(0); flush("event mask");
    wr(8'h0c, 32'h3f);
    wr(8'h44, 50); wr(8'h00, 32'h10); ex(0); cur(550); tk(3); chk(ost, 1, "group one");
    apb(0, 8'h10, 0); chk(rdat[7:3], 5'h05, "condition start");
    wr(8'h24, 0); apb(0, 8'h2c, 0);
    chk(rdat[26:16], {3'h1, 1'b0, 3'(1 << ph), 1'b0, 3'h0}, "record header");
    apb(0, 8'h30, 0); chk(rdat[15:0], 550, "record current");
    ex(1); wr(8'h00, 0); flush("group switch"); cur(0);
    apb(0, 8'h18, 0); chk(rdat, 4, "start count");
    apb(0, 8'h1c, 0); chk(rdat, 1, "trip count");
    apb(0, 8'h20, 0); chk(rdat, 2, "block count");
    for (int m = 0; m < 5; m++) begin
      wr(8'h00, m); apb(0, 8'h10, 0); chk(rdat[2:0], m, "mode");
    end
    wr(8'h00, 0); $display("test modes done");
    lock <= 1; theta <= 701; tk(2); chk({hot, stall}, {1'b1, 13'h0096}, "hot curve");
    theta <= 700; tk(2); chk({hot, stall}, {1'b0, 13'h003c}, "cold curve");
    lock <= 0; mst <= 1; wr(8'h00, 8); theta <= 701; tk(2); chk(hot, 1, "start hot");
    wr(8'h00, 0); tk(2); chk({hot, stall}, {1'b0, 13'h00c8}, "no curve");
    wr(8'h04, 32'h0096_0000); tk(2); chk(stall, 150, "cold follows hot");
    $display("test curves done");
    close_out;
  end
endmodule // mjs_jam_stage_tb_top
